// File: verilog/rgbdim_pkg.sv
// Constants and types for the RGB LED dimming command decoder
// Overview of operation
// - A start command walks the current level one step at a time toward the target.
// - Target comes from rise or fall register; step duration from the step-time register.
// - Current level always stays within the five-bit step range 0 to 31; the maximum current step does not bound it.
// - Upward ramp past a lower target wraps through maximum and zero; downward likewise.
// - A ramp has few steps; per-step delay comes from the command's low five bits.
// - A maximum-current command sets the level directly on acknowledge, without ramping.
// - A command byte takes effect only when the bus decoder acknowledges it.
// - Each register is loaded by its own address-plus-command transfer, in any order.
// - Selector 000 shuts down, forcing the current level to zero; low bits ignored.
// - Selector 001 stores the low bits as the maximum current step for all LEDs.
// - Selectors 010, 011, 100 store duty values for LED one, two, three.
// - Selector 101 stores the rise target, 110 the fall target, as step counts.
// - Selector 111 stores the step time and starts the ramp immediately.
// - Ramp length is the distance from present to target step.
// - Five-bit step codes limit a ramp to 31 steps.
// - Step-time field weighs 8 ms per unit, up to 128 ms for the top bit.
// - Step zero means no current; steps 30 and 31 give the same peak current.
// - Write-only target at write address 0x70, one command byte per frame.
// - The ramp never alters the duty registers.
`default_nettype none
package rgbdim_pkg;
   localparam int         LVL_W          = 5;
   localparam logic [7:0] BUS_WRITE_ADDR = 8'h70;
   localparam logic [4:0] LVL_ZERO       = 5'h00;
   localparam logic [4:0] LVL_ONE        = 5'h01;
   localparam logic [4:0] LVL_TOP        = 5'h1F;
   localparam logic [4:0] LVL_PEAK       = 5'h1E;
   localparam logic [3:0] BIT_CNT_ZERO   = 4'h0;
   localparam logic [3:0] BIT_CNT_ONE    = 4'h1;
   localparam logic [3:0] ACK_SLOT       = 4'h8;
   localparam logic [7:0] BYTE_ZERO      = 8'h00;
   localparam int         STEP_UNIT_MS   = 8;
   localparam int         NS_PER_MS      = 1000000;
   localparam int         CLK_PERIOD_NS  = 5;
   localparam int         STEP_UNIT_CYCLES = STEP_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      CMD_SHUTDOWN    = 3'h0,
      CMD_MAX_CURRENT = 3'h1,
      CMD_LED1_DUTY   = 3'h2,
      CMD_LED2_DUTY   = 3'h3,
      CMD_LED3_DUTY   = 3'h4,
      CMD_RISE_TARGET = 3'h5,
      CMD_FALL_TARGET = 3'h6,
      CMD_STEP_TIME   = 3'h7
   } rgbdim_cmd_t;

   typedef struct packed {
      rgbdim_cmd_t      sel;
      logic [LVL_W-1:0] arg;
   } rgbdim_byte_t;

   typedef enum logic [1:0] {
      BYTE_ADDR,
      BYTE_CMD,
      BYTE_EXTRA
   } rgbdim_phase_t;

   typedef enum logic {
      RAMP_IDLE,
      RAMP_RUN
   } rgbdim_state_t;
endpackage : rgbdim_pkg
`default_nettype wire

// File: verilog/rgbdim_decoder.sv
// Write-only serial command decoder and gradual dimming sequencer
`default_nettype none
module rgbdim_decoder #(
   parameter int         STEP_UNIT_CYCLES = rgbdim_pkg::STEP_UNIT_CYCLES,
   parameter logic [7:0] DEV_WRITE_ADDR   = rgbdim_pkg::BUS_WRITE_ADDR
) (
   input  wire logic                         ref_clk,
   input  wire logic                         rst_b,
   input  wire logic                         clk_en,
   input  wire logic                         scl_clk,
   input  wire logic                         sda_in,
   output logic                              sda_out,
   output logic                              sda_oe,
   output logic [rgbdim_pkg::LVL_W-1:0]      led_current_level,
   output logic [rgbdim_pkg::LVL_W-1:0]      peak_current_level,
   output logic [rgbdim_pkg::LVL_W-1:0]      max_current_step,
   output logic [rgbdim_pkg::LVL_W-1:0]      led1_duty,
   output logic [rgbdim_pkg::LVL_W-1:0]      led2_duty,
   output logic [rgbdim_pkg::LVL_W-1:0]      led3_duty,
   output logic [rgbdim_pkg::LVL_W-1:0]      rise_target_step,
   output logic [rgbdim_pkg::LVL_W-1:0]      fall_target_step,
   output logic [rgbdim_pkg::LVL_W-1:0]      ramp_step_time,
   output logic [rgbdim_pkg::LVL_W-1:0]      ramp_target_level,
   output logic [rgbdim_pkg::LVL_W-1:0]      ramp_steps_left,
   output logic                              ramp_busy,
   output logic                              frame_active
);
   localparam int UW = $clog2(STEP_UNIT_CYCLES + 1);
   localparam logic [UW-1:0] UNIT_LAST = UW'(STEP_UNIT_CYCLES - 1);

   generate
      if (STEP_UNIT_CYCLES < 1) begin : g_bad_unit
         $error("STEP_UNIT_CYCLES must be at least one");
      end
      // The address byte ends in the direction bit; this target only accepts writes
      if (DEV_WRITE_ADDR[0] != 1'b0) begin : g_bad_addr
         $error("DEV_WRITE_ADDR must select the write direction");
      end
   endgenerate

   // Steps to walk: modulo 32, so a target behind the level wraps through top or zero
   function automatic logic [rgbdim_pkg::LVL_W-1:0] ramp_distance(
      input logic                         up,
      input logic [rgbdim_pkg::LVL_W-1:0] from_lvl,
      input logic [rgbdim_pkg::LVL_W-1:0] to_lvl
   );
      ramp_distance = up ? (to_lvl - from_lvl) : (from_lvl - to_lvl);
   endfunction : ramp_distance

   // Decodes a captured command of one kind on the cycle that applies it
   function automatic logic cmd_hit(
      input logic                     pulse,
      input rgbdim_pkg::rgbdim_byte_t byte_in,
      input rgbdim_pkg::rgbdim_cmd_t  sel_in
   );
      cmd_hit = pulse && (byte_in.sel == sel_in);
   endfunction : cmd_hit

   // ---------------- Reference domain: bus framing ----------------
   logic                 scl_s1_reg;
   logic                 scl_s2_reg;
   logic                 scl_s3_reg;
   logic                 sda_s1_reg;
   logic                 sda_s2_reg;
   logic                 sda_s3_reg;
   logic                 frame_reg;
   logic                 link_run_reg;
   logic                 start_det;
   logic                 stop_det;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_s3_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_s3_reg <= 1'b1;
      end else if (clk_en) begin
         scl_s1_reg <= scl_clk;
         scl_s2_reg <= scl_s1_reg;
         scl_s3_reg <= scl_s2_reg;
         sda_s1_reg <= sda_in;
         sda_s2_reg <= sda_s1_reg;
         sda_s3_reg <= sda_s2_reg;
      end
   end

   assign start_det = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg;
   assign stop_det  = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg;

   // A start (or repeated start) drops the link-side reset for one cycle so the
   // bit counter realigns before the first clock rise of the new frame
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_reg    <= 1'b0;
         link_run_reg <= 1'b0;
      end else if (clk_en) begin
         if (start_det) begin
            frame_reg <= 1'b1;
         end else if (stop_det) begin
            frame_reg <= 1'b0;
         end
         link_run_reg <= frame_reg && !start_det && !stop_det;
      end
   end

   assign frame_active = frame_reg;

   // ---------------- Link domain: serial receiver ----------------
   logic                      link_rst_b;
   logic [3:0]                bit_cnt_reg;
   logic [7:0]                shift_reg;
   logic                      addr_ok_reg;
   rgbdim_pkg::rgbdim_phase_t phase_reg;
   rgbdim_pkg::rgbdim_byte_t  cmd_hold_reg;
   logic                      cmd_tog_reg;
   logic                      ack_now;

   assign link_rst_b = rst_b && link_run_reg;

   // Not gated by clk_en: a frame still completes and is applied once clk_en returns
   // Count 8 marks the acknowledge slot, when the whole byte sits in shift_reg
   always_ff @(posedge scl_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         bit_cnt_reg <= rgbdim_pkg::BIT_CNT_ZERO;
         shift_reg   <= rgbdim_pkg::BYTE_ZERO;
         addr_ok_reg <= 1'b0;
         phase_reg   <= rgbdim_pkg::BYTE_ADDR;
      end else if (bit_cnt_reg != rgbdim_pkg::ACK_SLOT) begin
         shift_reg   <= {shift_reg[6:0], sda_in};
         bit_cnt_reg <= bit_cnt_reg + rgbdim_pkg::BIT_CNT_ONE;
      end else begin
         bit_cnt_reg <= rgbdim_pkg::BIT_CNT_ZERO;
         case (phase_reg)
            rgbdim_pkg::BYTE_ADDR: begin
               addr_ok_reg <= (shift_reg == DEV_WRITE_ADDR);
               phase_reg   <= rgbdim_pkg::BYTE_CMD;
            end
            default: begin
               phase_reg <= rgbdim_pkg::BYTE_EXTRA;
            end
         endcase
      end
   end

   // Held across frames: the reference domain reads it after the toggle settles
   // The toggle, not a pulse, crosses: one edge per command whatever the clock ratio
   always_ff @(posedge scl_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_hold_reg <= rgbdim_pkg::BYTE_ZERO;
         cmd_tog_reg  <= 1'b0;
      end else if (link_run_reg && bit_cnt_reg == rgbdim_pkg::ACK_SLOT
                   && phase_reg == rgbdim_pkg::BYTE_CMD && addr_ok_reg) begin
         cmd_hold_reg <= shift_reg;
         cmd_tog_reg  <= !cmd_tog_reg;
      end
   end

   // Only the address byte and one command byte are answered; more are refused
   assign ack_now = (bit_cnt_reg == rgbdim_pkg::ACK_SLOT) &&
                    (((phase_reg == rgbdim_pkg::BYTE_ADDR) && (shift_reg == DEV_WRITE_ADDR))
                     || ((phase_reg == rgbdim_pkg::BYTE_CMD) && addr_ok_reg));

   always_ff @(negedge scl_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= ack_now;
      end
   end

   // Open drain: the pin is only ever pulled low
   assign sda_out = 1'b0;

   // ---------------- Reference domain: command capture ----------------
   logic                     tog_s1_reg;
   logic                     tog_s2_reg;
   logic                     tog_s3_reg;
   logic                     cmd_pulse;
   rgbdim_pkg::rgbdim_byte_t cmd;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tog_s1_reg <= 1'b0;
         tog_s2_reg <= 1'b0;
         tog_s3_reg <= 1'b0;
      end else if (clk_en) begin
         tog_s1_reg <= cmd_tog_reg;
         tog_s2_reg <= tog_s1_reg;
         tog_s3_reg <= tog_s2_reg;
      end
   end

   assign cmd_pulse = clk_en && (tog_s2_reg != tog_s3_reg);
   assign cmd       = cmd_hold_reg;

   // ---------------- Parameter registers ----------------
   logic [rgbdim_pkg::LVL_W-1:0] max_step_reg;
   logic [rgbdim_pkg::LVL_W-1:0] duty1_reg;
   logic [rgbdim_pkg::LVL_W-1:0] duty2_reg;
   logic [rgbdim_pkg::LVL_W-1:0] duty3_reg;
   logic [rgbdim_pkg::LVL_W-1:0] rise_reg;
   logic [rgbdim_pkg::LVL_W-1:0] fall_reg;
   logic [rgbdim_pkg::LVL_W-1:0] step_time_reg;
   logic                         dir_up_reg;

   // Duty values change only through their own commands, never from the ramp
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         duty1_reg <= rgbdim_pkg::LVL_ZERO;
         duty2_reg <= rgbdim_pkg::LVL_ZERO;
         duty3_reg <= rgbdim_pkg::LVL_ZERO;
      end else if (cmd_pulse) begin
         case (cmd.sel)
            rgbdim_pkg::CMD_LED1_DUTY: duty1_reg <= cmd.arg;
            rgbdim_pkg::CMD_LED2_DUTY: duty2_reg <= cmd.arg;
            rgbdim_pkg::CMD_LED3_DUTY: duty3_reg <= cmd.arg;
            default: ;
         endcase
      end
   end

   // The last target written picks the direction of the next ramp
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         max_step_reg  <= rgbdim_pkg::LVL_ZERO;
         rise_reg      <= rgbdim_pkg::LVL_ZERO;
         fall_reg      <= rgbdim_pkg::LVL_ZERO;
         step_time_reg <= rgbdim_pkg::LVL_ZERO;
         dir_up_reg    <= 1'b1;
      end else if (cmd_pulse) begin
         case (cmd.sel)
            rgbdim_pkg::CMD_MAX_CURRENT: begin
               max_step_reg <= cmd.arg;
            end
            rgbdim_pkg::CMD_RISE_TARGET: begin
               rise_reg   <= cmd.arg;
               dir_up_reg <= 1'b1;
            end
            rgbdim_pkg::CMD_FALL_TARGET: begin
               fall_reg   <= cmd.arg;
               dir_up_reg <= 1'b0;
            end
            rgbdim_pkg::CMD_STEP_TIME: begin
               step_time_reg <= cmd.arg;
            end
            default: ;
         endcase
      end
   end

   // ---------------- Ramp sequencer ----------------
   rgbdim_pkg::rgbdim_state_t    state_reg;
   logic [rgbdim_pkg::LVL_W-1:0] level_reg;
   logic [rgbdim_pkg::LVL_W-1:0] steps_reg;
   logic [UW-1:0]                unit_cnt_reg;
   logic [rgbdim_pkg::LVL_W-1:0] tick_cnt_reg;
   logic [rgbdim_pkg::LVL_W-1:0] target_sel;
   logic [rgbdim_pkg::LVL_W-1:0] start_dist;
   logic                         step_due;
   logic                         shutdown_hit;
   logic                         set_level_hit;
   logic                         start_hit;

   assign target_sel = dir_up_reg ? rise_reg : fall_reg;
   assign start_dist = ramp_distance(dir_up_reg, level_reg, target_sel);
   // Step time n waits n units of 8 ms; n of zero steps on every enabled cycle
   assign step_due   = (tick_cnt_reg == step_time_reg);

   // Shutdown and a max-current write abort a running ramp at once
   assign shutdown_hit  = cmd_hit(cmd_pulse, cmd, rgbdim_pkg::CMD_SHUTDOWN);
   assign set_level_hit = cmd_hit(cmd_pulse, cmd, rgbdim_pkg::CMD_MAX_CURRENT);
   assign start_hit     = cmd_hit(cmd_pulse, cmd, rgbdim_pkg::CMD_STEP_TIME);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg    <= rgbdim_pkg::RAMP_IDLE;
         level_reg    <= rgbdim_pkg::LVL_ZERO;
         steps_reg    <= rgbdim_pkg::LVL_ZERO;
         unit_cnt_reg <= '0;
         tick_cnt_reg <= rgbdim_pkg::LVL_ZERO;
      end else if (clk_en) begin
         if (shutdown_hit) begin
            level_reg <= rgbdim_pkg::LVL_ZERO;
            steps_reg <= rgbdim_pkg::LVL_ZERO;
            state_reg <= rgbdim_pkg::RAMP_IDLE;
         end else if (set_level_hit) begin
            level_reg <= cmd.arg;
            steps_reg <= rgbdim_pkg::LVL_ZERO;
            state_reg <= rgbdim_pkg::RAMP_IDLE;
         end else if (start_hit) begin
            // A restart mid-ramp is taken from the present level
            steps_reg    <= start_dist;
            unit_cnt_reg <= '0;
            tick_cnt_reg <= rgbdim_pkg::LVL_ZERO;
            state_reg    <= (start_dist == rgbdim_pkg::LVL_ZERO) ?
                            rgbdim_pkg::RAMP_IDLE : rgbdim_pkg::RAMP_RUN;
         end else begin
            case (state_reg)
               rgbdim_pkg::RAMP_RUN: begin
                  if (step_due) begin
                     // Five-bit wrap keeps the level inside 0..31 whatever was written
                     level_reg    <= dir_up_reg ? level_reg + rgbdim_pkg::LVL_ONE
                                                : level_reg - rgbdim_pkg::LVL_ONE;
                     steps_reg    <= steps_reg - rgbdim_pkg::LVL_ONE;
                     unit_cnt_reg <= '0;
                     tick_cnt_reg <= rgbdim_pkg::LVL_ZERO;
                     if (steps_reg == rgbdim_pkg::LVL_ONE) begin
                        state_reg <= rgbdim_pkg::RAMP_IDLE;
                     end
                  end else if (unit_cnt_reg == UNIT_LAST) begin
                     unit_cnt_reg <= '0;
                     tick_cnt_reg <= tick_cnt_reg + rgbdim_pkg::LVL_ONE;
                  end else begin
                     unit_cnt_reg <= unit_cnt_reg + UW'(1);
                  end
               end
               default: begin
                  state_reg <= rgbdim_pkg::RAMP_IDLE;
               end
            endcase
         end
      end
   end

   // ---------------- Outputs ----------------
   assign led_current_level  = level_reg;
   // Codes 30 and 31 drive the same peak current
   assign peak_current_level = (level_reg == rgbdim_pkg::LVL_TOP) ?
                               rgbdim_pkg::LVL_PEAK : level_reg;
   assign max_current_step   = max_step_reg;
   assign led1_duty          = duty1_reg;
   assign led2_duty          = duty2_reg;
   assign led3_duty          = duty3_reg;
   assign rise_target_step   = rise_reg;
   assign fall_target_step   = fall_reg;
   assign ramp_step_time     = step_time_reg;
   assign ramp_target_level  = target_sel;
   assign ramp_steps_left    = steps_reg;
   assign ramp_busy          = (state_reg == rgbdim_pkg::RAMP_RUN);
endmodule : rgbdim_decoder
`default_nettype wire

// File: test/rgbdim_dec_props.sv
// Concurrent checks on the dimming decoder ports
`default_nettype none
module rgbdim_dec_props (
   input wire logic       ref_clk,
   input wire logic       rst_b,
   input wire logic       sda_oe,
   input wire logic [4:0] led_current_level,
   input wire logic [4:0] peak_current_level,
   input wire logic [4:0] led1_duty,
   input wire logic [4:0] led2_duty,
   input wire logic [4:0] led3_duty,
   input wire logic [4:0] ramp_target_level,
   input wire logic [4:0] ramp_steps_left,
   input wire logic       ramp_busy,
   input wire logic       frame_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_ack_idle: assert property (!frame_active |-> !sda_oe)
      else $error("ack driven outside a frame");
   // Ack stands one bus period, about 32 system cycles
   a_ack_span: assert property ($rose(sda_oe) |-> sda_oe [*8] ##[20:30] !sda_oe)
      else $error("ack slot length wrong");
   a_peak_map: assert property (peak_current_level ==
      ((led_current_level == 5'h1F) ? 5'h1E : led_current_level))
      else $error("peak level mapping wrong");
   a_end_hold: assert property ($fell(ramp_busy) && $past(ramp_steps_left) == 5'h01
      |-> led_current_level == ramp_target_level)
      else $error("ramp ended off target");
   a_step_one: assert property (ramp_busy && $past(ramp_busy)
      && led_current_level != $past(led_current_level)
      |-> led_current_level == $past(led_current_level) + 5'h01
      || led_current_level == $past(led_current_level) - 5'h01)
      else $error("ramp moved more than one step");
   a_step_pace: assert property (ramp_busy && $past(ramp_busy)
      |-> (ramp_steps_left != $past(ramp_steps_left))
      == (led_current_level != $past(led_current_level)))
      else $error("step count and level out of step");
   a_busy_left: assert property (ramp_busy |-> ramp_steps_left != 5'h00)
      else $error("busy with no steps left");
   a_duty_keep: assert property (ramp_busy && !frame_active && !$past(frame_active)
      |-> $stable({led1_duty, led2_duty, led3_duty}))
      else $error("duty changed during ramp");
   a_idle_hold: assert property (!ramp_busy && !$past(ramp_busy) && !frame_active
      && !$past(frame_active) |-> $stable(led_current_level))
      else $error("level changed without a command");

   c_ramp_done: cover property ($fell(ramp_busy));
   c_wrap: cover property (ramp_busy && led_current_level == 5'h00
      && $past(led_current_level) == 5'h1F);
   c_ack: cover property ($rose(sda_oe));
endmodule : rgbdim_dec_props

bind rgbdim_decoder rgbdim_dec_props i_props (
   .ref_clk(ref_clk), .rst_b(rst_b), .sda_oe(sda_oe),
   .led_current_level(led_current_level), .peak_current_level(peak_current_level),
   .led1_duty(led1_duty), .led2_duty(led2_duty), .led3_duty(led3_duty),
   .ramp_target_level(ramp_target_level), .ramp_steps_left(ramp_steps_left),
   .ramp_busy(ramp_busy), .frame_active(frame_active)
);
`default_nettype wire

// File: test/rgbdim_bus_master.sv
// Serial bus master model that writes command frames
`default_nettype none
module rgbdim_bus_master (
   output logic     scl_clk,
   output logic     sda_drv,
   input wire logic sda_wire
);
   timeunit 1ns;
   timeprecision 100ps;

   // Bus clock stands high between frames
   initial begin
      scl_clk = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic put_bit(input logic b, output logic seen);
      scl_clk = 1'b0;
      #20 sda_drv = b;
      #60 scl_clk = 1'b1;
      seen = sda_wire;
      #80;
   endtask : put_bit

   // One frame of n bytes; ack bit set where the byte was acknowledged
   task automatic send(input logic [23:0] bytes, input int n, output logic [2:0] ack);
      logic       s;
      logic [7:0] b;
      ack = 3'h0;
      #1.7 sda_drv = 1'b0;
      #80;
      for (int i = 0; i < n; i++) begin
         b = bytes[23-8*i -: 8];
         for (int j = 7; j >= 0; j--) begin
            put_bit(b[j], s);
         end
         put_bit(1'b1, s);
         ack[2-i] = !s;
      end
      scl_clk = 1'b0;
      #20 sda_drv = 1'b0;
      #60 scl_clk = 1'b1;
      #40 sda_drv = 1'b1;
      #80;
   endtask : send
endmodule : rgbdim_bus_master
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the dimming command decoder
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int UNIT_CYC = 4;
   logic        ref_clk, rst_b, clk_en, scl_clk, sda_drv, sda_out, sda_oe, busy, busy_q;
   logic [4:0]  lvl_o, peak_o, max_o, d1_o, d2_o, d3_o, rise_o, fall_o, st_o, tgt_o, left_o;
   logic        frame_o;
   wire         sda_wire;
   int          err_total, checks, lvl, mx, rise, fall, st, up, busy_cnt;
   int          duty [3];
   logic [31:0] seed;

   // Pull-up resolves the open-drain wire
   assign sda_wire = sda_drv & ~(sda_oe & ~sda_out);

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   rgbdim_bus_master i_mst (.scl_clk(scl_clk), .sda_drv(sda_drv), .sda_wire(sda_wire));

   rgbdim_decoder #(.STEP_UNIT_CYCLES(UNIT_CYC)) i_dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .scl_clk(scl_clk),
      .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .led_current_level(lvl_o),
      .peak_current_level(peak_o), .max_current_step(max_o), .led1_duty(d1_o),
      .led2_duty(d2_o), .led3_duty(d3_o), .rise_target_step(rise_o),
      .fall_target_step(fall_o), .ramp_step_time(st_o), .ramp_target_level(tgt_o),
      .ramp_steps_left(left_o), .ramp_busy(busy), .frame_active(frame_o));

   always @(posedge ref_clk) begin
      busy_q <= busy;
      if (busy && !busy_q)
         busy_cnt <= 1;
      else if (busy)
         busy_cnt <= busy_cnt + 1;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input string nm, input int exp, input logic [15:0] got);
      checks++;
      if (got !== 16'(exp)) begin
         err_total++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   task automatic summarize();
      if (err_total == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   task automatic cmp_all();
      chk("level", lvl, lvl_o);
      chk("peak", (lvl == 31) ? 30 : lvl, peak_o);
      chk("max_step", mx, max_o);
      chk("duty1", duty[0], d1_o);
      chk("duty2", duty[1], d2_o);
      chk("duty3", duty[2], d3_o);
      chk("rise", rise, rise_o);
      chk("fall", fall, fall_o);
      chk("step_time", st, st_o);
      chk("target", up ? rise : fall, tgt_o);
      chk("left", 0, left_o);
      chk("frame", 0, frame_o);
   endtask : cmp_all

   task automatic cmd(input logic [7:0] addr, input logic [2:0] sel, input logic [4:0] arg,
                      input int n);
      logic [2:0] ack;
      int         steps;
      steps = 0;
      i_mst.send({addr, sel, arg, 8'hA5}, n, ack);
      chk("ack", (addr == rgbdim_pkg::BUS_WRITE_ADDR) ? 6 : 0, ack);
      if (addr == rgbdim_pkg::BUS_WRITE_ADDR) begin
         case (sel)
            3'h0: lvl = 0;
            3'h1: begin
               mx = arg;
               lvl = arg;
            end
            3'h5: begin
               rise = arg;
               up = 1;
            end
            3'h6: begin
               fall = arg;
               up = 0;
            end
            3'h7: begin
               st = arg;
               steps = up ? (rise - lvl) & 31 : (lvl - fall) & 31;
               lvl = up ? rise : fall;
            end
            default: duty[int'(sel)-2] = arg;
         endcase
      end
      for (int k = 0; k < 5000 && (busy || k < 10); k++) begin
         @(negedge ref_clk);
      end
      if (busy) begin
         chk("timeout", 0, busy);
         summarize();
      end
      if (steps > 0)
         chk("ramp_cycles", steps * (UNIT_CYC * arg + 1), 16'(busy_cnt));
      chk("busy", 0, busy);
      cmp_all();
   endtask : cmd

   initial begin
      rst_b = 1'b0;
      clk_en = 1'b0;
      seed = 32'h00001821;
      err_total = 0;
      checks = 0;
      lvl = 0;
      mx = 0;
      rise = 0;
      fall = 0;
      st = 0;
      up = 1;
      duty = '{0, 0, 0};
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      clk_en <= 1'b1;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      cmp_all();
      for (int s = 1; s < 7; s++) cmd(8'h70, 3'(s), 5'(rnd()), 2);
      cmd(8'h70, 3'h0, 5'(rnd()), 2);
      cmd(8'h70, 3'h1, 5'h1F, 3);
      cmd(8'h70, 3'h1, 5'h05, 2);
      cmd(8'h70, 3'h5, 5'h0F, 2);
      cmd(8'h70, 3'h7, 5'h01, 2);
      cmd(8'h70, 3'h1, 5'h14, 2);
      cmd(8'h70, 3'h5, 5'h03, 2);
      cmd(8'h70, 3'h7, 5'h00, 2);
      cmd(8'h70, 3'h6, 5'h14, 2);
      cmd(8'h70, 3'h7, 5'h02, 2);
      cmd(8'h71, 3'h1, 5'h09, 2);
      cmd(8'h70, 3'h1, 5'h00, 2);
      cmd(8'h70, 3'h5, 5'h1F, 2);
      cmd(8'h70, 3'h7, 5'h1F, 2);
      repeat (6) begin
         cmd(8'h70, 3'(2 + rnd() % 5), 5'(rnd()), 2);
         cmd(8'h70, 3'h7, 5'(rnd() & 32'h00000003), 2);
      end
      summarize();
   end
endmodule : tb_top
`default_nettype wire
